// ---- hdl/alu_io_pkg.sv ----
package alu_io_pkg;
	localparam logic [7:0] FULL_MASK = 8'hFF;
	localparam logic [7:0] BIT_IO_LAST = 8'h1F;
	localparam logic [7:0] PORT_IO_LAST = 8'h3F;
	localparam logic [15:0] DATA_IO_OFFSET = 16'h0020;
	localparam logic [7:0] DATA_IO_LAST = 8'h5F;
	localparam int SREG_C = 0;
	localparam int SREG_Z = 1;
	localparam int SREG_N = 2;
	localparam int SREG_V = 3;
	localparam int SREG_S = 4;
	localparam int SREG_H = 5;
	localparam logic [7:0] SREG_RESET = 8'h00;
	localparam logic [7:0] WORD_CYCLES = 8'h02;

	typedef enum logic [4:0] {
		OP_ADD = 5'h00, OP_ADC = 5'h01, OP_WORD_ADD_IMM = 5'h02, OP_SUB = 5'h03, OP_MINUS_CONST = 5'h04,
		OP_MINUS_BORROW = 5'h05, OP_MINUS_CONST_BORROW = 5'h06, OP_WORD_MINUS_IMM = 5'h07, OP_AND = 5'h08,
		OP_AND_CONST = 5'h09,
		OP_OR = 5'h0A, OP_OR_CONST = 5'h0B, OP_XOR = 5'h0C, OP_SETMASK = 5'h0D, OP_CLRMASK = 5'h0E,
		OP_IO_SET = 5'h0F, OP_IO_CLR = 5'h10, OP_SKIP_HI = 5'h11, OP_SKIP_LO = 5'h12,
		OP_IO_IN = 5'h13, OP_IO_OUT = 5'h14, OP_MEM_RD = 5'h15, OP_MEM_WR = 5'h16, OP_NOP = 5'h1F
	} op_t;

	typedef enum logic [2:0] {
		STATE_IDLE = 3'b001,
		STATE_WORD2 = 3'b010,
		STATE_IO_RMW = 3'b100
	} state_t;

	typedef struct packed {
		logic valid;
		op_t op;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] dst_hi;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [15:0] addr;
		logic [7:0] io_rdata;
		logic [7:0] w1c_mask;
	} req_t;

	typedef struct packed {
		logic done;
		logic wr_dst;
		logic wr_pair;
		logic [7:0] result;
		logic [7:0] result_hi;
		logic [7:0] sreg;
		logic skip;
		logic io_we;
		logic [5:0] io_addr;
		logic [7:0] io_wdata;
		logic io_re;
		logic addr_err;
	} rsp_t;

	typedef struct packed {
		state_t state;
		req_t held;
		logic [15:0] word_res;
		logic [7:0] sreg;
		rsp_t rsp;
	} core_state_t;
endpackage

// ---- hdl/alu_io_datapath.sv ----
`timescale 1ns/1ps
// Contract
// - Add and add-with-carry write dst plus source (plus carry) in one cycle; Z,C,N,V,H.
// - Word add immediate adds constant to 16-bit pair in two cycles; Z,C,N,V,S.
// - Subtract and subtract-constant store difference in one cycle; Z,C,N,V,H.
// - Subtract-with-borrow forms subtract operand and carry in one cycle; Z,C,N,V,H.
// - Word subtract immediate subtracts constant from 16-bit pair in two cycles; Z,C,N,V,S.
// - AND with register or constant in one cycle; only Z,N,V,S change.
// - OR, OR-constant and XOR in one cycle; only Z,N,V,S change.
// - Bit set mask ORs constant into destination in one cycle; Z,N,V,S only.
// - Bit clear mask ANDs with 0xFF minus constant in one cycle; Z,N,V,S only.
// - Bit set, clear and skip work only on I/O addresses 0x00 to 0x1F.
// - Writing one clears a status flag; writing zero leaves it.
// - Single-bit I/O set and clear touch only the addressed bit.
// - Port read and write instructions use I/O addresses 0x00 to 0x3F.
// - Data-space access maps I/O registers at I/O address plus 0x20.
module alu_io_datapath
	import alu_io_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire req_t req_in,
	output logic busy_out,
	output rsp_t rsp_out
);
	core_state_t cur_ff;
	core_state_t nxt_ff;

	logic [8:0] sum9;
	logic [7:0] res8;
	logic [7:0] a8;
	logic [7:0] b8;
	logic cin;
	logic half;
	logic ovf;
	logic is_sub;
	logic [15:0] pair;
	logic [15:0] word16;
	logic [7:0] bit_mask;
	logic [15:0] io_off;

	// Busy only during the second cycle of two-cycle ops
	assign busy_out = (cur_ff.state != STATE_IDLE);
	assign rsp_out = cur_ff.rsp;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.rsp = '0;
		nxt_ff.rsp.sreg = cur_ff.sreg;
		a8 = req_in.dst;
		b8 = req_in.src;
		cin = 1'b0;
		is_sub = 1'b0;
		sum9 = 9'h000;
		res8 = 8'h00;
		half = 1'b0;
		ovf = 1'b0;
		pair = {req_in.dst_hi, req_in.dst};
		word16 = 16'h0000;
		bit_mask = 8'h01 << req_in.bit_sel;
		io_off = req_in.addr - DATA_IO_OFFSET;
		case (req_in.op)
			// Constant forms take the immediate as second operand; clear mask takes 0xFF minus the immediate
			OP_MINUS_CONST, OP_MINUS_CONST_BORROW, OP_AND_CONST, OP_OR_CONST, OP_SETMASK: b8 = req_in.imm;
			OP_CLRMASK: b8 = FULL_MASK - req_in.imm;
			default: b8 = req_in.src;
		endcase
		// Carry-in only for the carry and borrow forms
		case (req_in.op)
			OP_ADC, OP_MINUS_BORROW, OP_MINUS_CONST_BORROW: cin = cur_ff.sreg[SREG_C];
			default: cin = 1'b0;
		endcase
		is_sub = (req_in.op == OP_SUB) || (req_in.op == OP_MINUS_CONST) || (req_in.op == OP_MINUS_BORROW)
			|| (req_in.op == OP_MINUS_CONST_BORROW);
		// Borrow lands in the ninth bit
		if (is_sub) begin
			sum9 = {1'b0, a8} - {1'b0, b8} - {8'h00, cin};
		end else begin
			sum9 = {1'b0, a8} + {1'b0, b8} + {8'h00, cin};
		end
		res8 = sum9[7:0];
		if (is_sub) begin
			half = (~a8[3] & b8[3]) | (b8[3] & res8[3]) | (res8[3] & ~a8[3]);
			ovf = (a8[7] & ~b8[7] & ~res8[7]) | (~a8[7] & b8[7] & res8[7]);
		end else begin
			half = (a8[3] & b8[3]) | (b8[3] & ~res8[3]) | (~res8[3] & a8[3]);
			ovf = (a8[7] & b8[7] & ~res8[7]) | (~a8[7] & ~b8[7] & res8[7]);
		end

		case (cur_ff.state)
			STATE_IDLE: begin
				if (req_in.valid) begin
					nxt_ff.held = req_in;
					nxt_ff.rsp.done = 1'b1;
					case (req_in.op)
						OP_ADD, OP_ADC, OP_SUB, OP_MINUS_CONST, OP_MINUS_BORROW, OP_MINUS_CONST_BORROW: begin
							nxt_ff.rsp.wr_dst = 1'b1;
							nxt_ff.rsp.result = res8;
							nxt_ff.sreg[SREG_C] = sum9[8];
							nxt_ff.sreg[SREG_Z] = (res8 == 8'h00);
							nxt_ff.sreg[SREG_N] = res8[7];
							nxt_ff.sreg[SREG_V] = ovf;
							nxt_ff.sreg[SREG_H] = half;
							nxt_ff.sreg[SREG_S] = res8[7] ^ ovf;
						end
						// Flags settle now; the pair result leaves next cycle
						OP_WORD_ADD_IMM, OP_WORD_MINUS_IMM: begin
							if (req_in.op == OP_WORD_ADD_IMM) begin
								word16 = pair + {8'h00, req_in.imm};
								nxt_ff.sreg[SREG_C] = ~word16[15] & pair[15];
								nxt_ff.sreg[SREG_V] = ~pair[15] & word16[15];
							end else begin
								word16 = pair - {8'h00, req_in.imm};
								nxt_ff.sreg[SREG_C] = word16[15] & ~pair[15];
								nxt_ff.sreg[SREG_V] = pair[15] & ~word16[15];
							end
							nxt_ff.sreg[SREG_Z] = (word16 == 16'h0000);
							nxt_ff.sreg[SREG_N] = word16[15];
							nxt_ff.sreg[SREG_S] = word16[15] ^ nxt_ff.sreg[SREG_V];
							nxt_ff.word_res = word16;
							nxt_ff.rsp.done = 1'b0;
							nxt_ff.state = STATE_WORD2;
						end
						// Logic ops keep carry and half-carry
						OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR, OP_SETMASK, OP_CLRMASK: begin
							case (req_in.op)
								OP_AND, OP_AND_CONST, OP_CLRMASK: res8 = a8 & b8;
								OP_XOR: res8 = a8 ^ b8;
								default: res8 = a8 | b8;
							endcase
							nxt_ff.rsp.wr_dst = 1'b1;
							nxt_ff.rsp.result = res8;
							nxt_ff.sreg[SREG_Z] = (res8 == 8'h00);
							nxt_ff.sreg[SREG_N] = res8[7];
							nxt_ff.sreg[SREG_V] = 1'b0;
							nxt_ff.sreg[SREG_S] = res8[7];
						end
						OP_IO_SET, OP_IO_CLR: begin
							if (req_in.addr[7:0] <= BIT_IO_LAST && req_in.addr[15:8] == 8'h00) begin
								nxt_ff.rsp.done = 1'b0;
								nxt_ff.state = STATE_IO_RMW;
							end else begin
								nxt_ff.rsp.addr_err = 1'b1;
							end
						end
						OP_SKIP_HI, OP_SKIP_LO: begin
							if (req_in.addr[7:0] <= BIT_IO_LAST && req_in.addr[15:8] == 8'h00) begin
								nxt_ff.rsp.io_re = 1'b1;
								nxt_ff.rsp.io_addr = req_in.addr[5:0];
								nxt_ff.rsp.skip = (req_in.op == OP_SKIP_HI) ? |(req_in.io_rdata & bit_mask)
									: ~|(req_in.io_rdata & bit_mask);
							end else begin
								nxt_ff.rsp.addr_err = 1'b1;
							end
						end
						OP_IO_IN, OP_IO_OUT: begin
							if (req_in.addr[7:0] <= PORT_IO_LAST && req_in.addr[15:8] == 8'h00) begin
								nxt_ff.rsp.io_addr = req_in.addr[5:0];
								nxt_ff.rsp.io_we = (req_in.op == OP_IO_OUT);
								nxt_ff.rsp.io_re = (req_in.op == OP_IO_IN);
								nxt_ff.rsp.io_wdata = req_in.dst;
								nxt_ff.rsp.wr_dst = (req_in.op == OP_IO_IN);
								nxt_ff.rsp.result = req_in.io_rdata;
							end else begin
								nxt_ff.rsp.addr_err = 1'b1;
							end
						end
						OP_MEM_RD, OP_MEM_WR: begin
							if (req_in.addr >= DATA_IO_OFFSET && req_in.addr <= {8'h00, DATA_IO_LAST}) begin
								nxt_ff.rsp.io_addr = io_off[5:0];
								nxt_ff.rsp.io_we = (req_in.op == OP_MEM_WR);
								nxt_ff.rsp.io_re = (req_in.op == OP_MEM_RD);
								nxt_ff.rsp.io_wdata = req_in.dst;
								nxt_ff.rsp.wr_dst = (req_in.op == OP_MEM_RD);
								nxt_ff.rsp.result = req_in.io_rdata;
							end else begin
								nxt_ff.rsp.addr_err = 1'b1;
							end
						end
						default: nxt_ff.rsp.done = 1'b1;
					endcase
				end else begin
					nxt_ff.rsp.done = 1'b0;
				end
			end
			STATE_WORD2: begin
				nxt_ff.rsp.done = 1'b1;
				nxt_ff.rsp.wr_pair = 1'b1;
				nxt_ff.rsp.result = cur_ff.word_res[7:0];
				nxt_ff.rsp.result_hi = cur_ff.word_res[15:8];
				nxt_ff.state = STATE_IDLE;
			end
			STATE_IO_RMW: begin
				// Write-one-to-clear flags other than the target are written as zero
				bit_mask = 8'h01 << cur_ff.held.bit_sel;
				nxt_ff.rsp.done = 1'b1;
				nxt_ff.rsp.io_we = 1'b1;
				nxt_ff.rsp.io_addr = cur_ff.held.addr[5:0];
				if (cur_ff.held.op == OP_IO_SET) begin
					nxt_ff.rsp.io_wdata = (cur_ff.held.io_rdata & ~cur_ff.held.w1c_mask) | bit_mask;
				end else begin
					nxt_ff.rsp.io_wdata = cur_ff.held.io_rdata & ~cur_ff.held.w1c_mask & ~bit_mask;
				end
				nxt_ff.state = STATE_IDLE;
			end
			default: nxt_ff.state = STATE_IDLE;
		endcase
		nxt_ff.rsp.sreg = nxt_ff.sreg;
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			cur_ff <= '0;
			// Flags and pulses cleared on reset
			cur_ff.state <= STATE_IDLE;
			cur_ff.sreg <= SREG_RESET;
		end else begin
			cur_ff <= nxt_ff;
		end
	end
endmodule

// ---- verif/alu_io_asserts.sv ----
`timescale 1ns/1ps
module alu_io_checker
	import alu_io_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire req_t req_in,
	input wire logic busy_out,
	input wire rsp_t rsp_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	logic tk;
	assign tk = req_in.valid && !busy_out;
	a_add_sum: assert property (tk && req_in.op == OP_ADD |=> rsp_out.done && rsp_out.wr_dst
		&& rsp_out.result == 8'($past(req_in.dst) + $past(req_in.src))) else $error("add result wrong");
	a_word_two_cycles: assert property (tk && req_in.op == OP_WORD_ADD_IMM |=> busy_out && !rsp_out.done
		##1 rsp_out.done && rsp_out.wr_pair) else $error("word add timing wrong");
	a_sub_borrow: assert property (tk && req_in.op == OP_SUB |=> rsp_out.sreg[SREG_C]
		== ($past(req_in.src) > $past(req_in.dst))) else $error("sub borrow wrong");
	a_and_flags: assert property (tk && req_in.op == OP_AND |=> !rsp_out.sreg[SREG_V]
		&& rsp_out.sreg[SREG_Z] == (rsp_out.result == 8'h00)) else $error("and flags wrong");
	a_clr_mask: assert property (tk && req_in.op == OP_CLRMASK |=> rsp_out.result
		== ($past(req_in.dst) & (FULL_MASK - $past(req_in.imm)))) else $error("clear mask wrong");
	a_io_set_bit: assert property (tk && req_in.op == OP_IO_SET && req_in.addr <= 16'(BIT_IO_LAST) |-> ##2 rsp_out.io_we
		&& rsp_out.io_wdata == (($past(req_in.io_rdata, 2) & ~$past(req_in.w1c_mask, 2))
		| (8'h01 << $past(req_in.bit_sel, 2)))) else $error("bit set write wrong");
	a_bit_range: assert property (tk && req_in.op == OP_IO_CLR && req_in.addr > 16'(BIT_IO_LAST)
		|-> ##[1:2] rsp_out.addr_err) else $error("bit op range wrong");
	a_port_range: assert property (tk && req_in.op == OP_IO_IN && req_in.addr > 16'(PORT_IO_LAST)
		|-> ##[1:2] rsp_out.addr_err) else $error("port range wrong");
	a_mem_offset: assert property (tk && req_in.op == OP_MEM_RD && req_in.addr == 16'h005F |=> rsp_out.io_re
		&& rsp_out.io_addr == 6'h3F) else $error("data space offset wrong");
	a_word_sub_value: assert property (tk && req_in.op == OP_WORD_MINUS_IMM |=> busy_out && !rsp_out.done
		##1 rsp_out.done && rsp_out.wr_pair && {rsp_out.result_hi, rsp_out.result}
		== 16'({$past(req_in.dst_hi, 2), $past(req_in.dst, 2)} - {8'h00, $past(req_in.imm, 2)}))
		else $error("word sub wrong");
	a_skip_high: assert property (tk && req_in.op == OP_SKIP_HI && req_in.addr <= 16'(BIT_IO_LAST) |=>
		rsp_out.skip == |($past(req_in.io_rdata) & (8'h01 << $past(req_in.bit_sel)))) else $error("skip wrong");
	a_xor_keeps_carry: assert property (tk && req_in.op == OP_XOR |=> rsp_out.sreg[SREG_C]
		== $past(rsp_out.sreg[SREG_C])) else $error("logic op changed carry");
	a_mem_write_map: assert property (tk && req_in.op == OP_MEM_WR && req_in.addr == 16'h0032 |=> rsp_out.io_we
		&& rsp_out.io_addr == 6'h12 && rsp_out.io_wdata == $past(req_in.dst)) else $error("data space write wrong");
endmodule
bind alu_io_datapath alu_io_checker i_chk (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(req_in),
	.busy_out(busy_out), .rsp_out(rsp_out));

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import alu_io_pkg::*;
;
	logic mclk_in = 0;
	logic rstn_in = 0;
	req_t r = '0;
	logic busy_out;
	rsp_t rsp_out;
	localparam logic [10:0] CTL_ALL = 11'h7FF;
	logic [43:0] eq[$];
	logic [43:0] mq[$];
	int err_total = 0;
	int checked = 0;
	int seed = 33;
	int i;
	logic [7:0] d, s, x;
	logic [15:0] f;
	logic c = 0;
	logic [4:0] ao[6] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h04, 5'h06};
	logic [7:0] ad[6] = '{8'hF0, 8'h01, 8'h00, 8'h10, 8'h05, 8'h09};
	logic [7:0] as[6] = '{8'h20, 8'h02, 8'h01, 8'h01, 8'h07, 8'h01};
	logic [4:0] lo[7] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E};
	logic [7:0] lx[7] = '{8'h24, 8'h24, 8'hBD, 8'hBD, 8'h99, 8'hBD, 8'h81};
	alu_io_datapath i_alu_io_datapath (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(r), .busy_out(busy_out),
		.rsp_out(rsp_out));
	always #5 mclk_in = ~mclk_in;
	function automatic logic [15:0] ar(input logic [7:0] a, input logic [7:0] b, input logic ci, input logic sb);
		logic [8:0] t;
		logic [4:0] h;
		logic v;
		t = sb ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
		h = sb ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
		v = sb ? (a[7] ^ b[7]) & (a[7] ^ t[7]) : ~(a[7] ^ b[7]) & (a[7] ^ t[7]);
		return {2'b00, h[4], t[7] ^ v, v, t[7], t[7:0] == 8'h00, t[8], t[7:0]};
	endfunction
	task automatic bad(input string m);
		$display("[ERR] %0t %s", $time, m);
		err_total++;
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Dst_hi from addr high byte, src, imm and bit select share b
	task automatic send(input logic [4:0] op, input logic [7:0] a, input logic [7:0] b, input logic [15:0] adr,
		input logic [43:0] e, input logic [43:0] m);
		r = '{1'b1, op_t'(op), a, b, adr[15:8], b, b[2:0], adr, 8'hC3, 8'h81};
		eq.push_back(e);
		mq.push_back(m);
		@(negedge mclk_in);
		for (int j = 0; j < 4 && busy_out === 1'b1; j++) @(negedge mclk_in);
		if (busy_out !== 1'b0) begin
			bad("busy stuck");
			summarize();
		end
	endtask
	always @(posedge mclk_in) begin
		#1;
		if (rsp_out.done === 1'b1) begin
			checked++;
			if (eq.size() == 0)
				bad("unexpected done");
			else if ((({rsp_out.skip, rsp_out.io_we, rsp_out.io_re, rsp_out.wr_dst, rsp_out.wr_pair, rsp_out.io_addr,
				rsp_out.addr_err, rsp_out.sreg, rsp_out.io_wdata, rsp_out.result_hi, rsp_out.result}
				^ eq.pop_front()) & mq.pop_front()) !== 44'h0)
				bad("result mismatch");
		end
	end
	initial begin
		repeat (5) @(negedge mclk_in);
		checked++;
		if (rsp_out !== '0 || busy_out !== 1'b0)
			bad("reset state wrong");
		rstn_in = 1;
		for (i = 0; i < 22; i++) begin
			d = (i < 6) ? ad[i] : (i < 8) ? 8'h80 : 8'($random(seed));
			s = (i < 6) ? as[i] : (i < 8) ? 8'h80 : 8'($random(seed));
			x = (i < 6) ? ao[i] : {4'h0, i[0]} * 5'h03;
			f = ar(d, s, (x == 5'h01 || x >= 5'h05) ? c : 1'b0, x >= 5'h03);
			c = f[8];
			send(x, d, s, 16'h0, {5'b00010, 6'h00, 1'b0, f[15:8], 16'h0, f[7:0]}, {CTL_ALL, 1'b1, 8'h2F, 16'h0, 8'hFF});
		end
		send(5'h02, 8'hFF, 8'h01, 16'h7F00, {5'b00001, 6'h00, 1'b0, 8'h0C, 24'h008000}, {CTL_ALL, 1'b1, 8'h1F, 24'h00FFFF});
		send(5'h07, 8'h00, 8'h01, 16'h0000, {5'b00001, 6'h00, 1'b0, 8'h15, 24'h00FFFF}, {CTL_ALL, 1'b1, 8'h1F, 24'h00FFFF});
		for (i = 0; i < 7; i++) begin
			send(lo[i], 8'hA5, 8'h3C, 16'h0, {5'b00010, 6'h00, 1'b0, 5'h00, lx[i][7], 18'h0, lx[i]}, {CTL_ALL, 1'b1, 8'h0E, 16'h0, 8'hFF});
		end
		send(5'h0F, 8'h00, 8'h02, 16'h001E, {5'b01000, 6'h1E, 9'h000, 8'h46, 16'h0}, {CTL_ALL, 9'h100, 8'hFF, 16'h0});
		send(5'h10, 8'h00, 8'h01, 16'h000B, {5'b01000, 6'h0B, 9'h000, 8'h40, 16'h0}, {CTL_ALL, 9'h100, 8'hFF, 16'h0});
		send(5'h10, 8'h00, 8'h01, 16'h0020, {11'h000, 1'b1, 32'h0}, {CTL_ALL, 1'b1, 32'h0});
		send(5'h11, 8'h00, 8'h01, 16'h000B, {5'b10100, 6'h0B, 1'b0, 32'h0}, {CTL_ALL, 1'b1, 32'h0});
		send(5'h12, 8'h00, 8'h01, 16'h000B, {5'b00100, 6'h0B, 1'b0, 32'h0}, {CTL_ALL, 1'b1, 32'h0});
		send(5'h11, 8'h00, 8'h01, 16'h0020, {11'h000, 1'b1, 32'h0}, {CTL_ALL, 1'b1, 32'h0});
		send(5'h13, 8'h00, 8'h00, 16'h0040, {11'h000, 1'b1, 32'h0}, {CTL_ALL, 1'b1, 32'h0});
		send(5'h13, 8'h00, 8'h00, 16'h003F, {5'b00110, 6'h3F, 1'b0, 24'h0, 8'hC3}, {CTL_ALL, 1'b1, 24'h0, 8'hFF});
		send(5'h14, 8'h5A, 8'h00, 16'h0012, {5'b01000, 6'h12, 1'b0, 8'h00, 8'h5A, 16'h0}, {CTL_ALL, 1'b1, 8'h00, 8'hFF, 16'h0});
		send(5'h15, 8'h00, 8'h00, 16'h005F, {5'b00110, 6'h3F, 1'b0, 24'h0, 8'hC3}, {CTL_ALL, 1'b1, 24'h0, 8'hFF});
		send(5'h16, 8'h5A, 8'h00, 16'h0032, {5'b01000, 6'h12, 1'b0, 8'h00, 8'h5A, 16'h0}, {CTL_ALL, 1'b1, 8'h00, 8'hFF, 16'h0});
		send(5'h15, 8'h00, 8'h00, 16'h001F, {11'h000, 1'b1, 32'h0}, {CTL_ALL, 1'b1, 32'h0});
		send(5'h1F, 8'h00, 8'h00, 16'h0000, 44'h0, {CTL_ALL, 1'b1, 32'h0});
		r.valid = 1'b0;
		repeat (2) @(negedge mclk_in);
		rstn_in = 0;
		repeat (2) @(negedge mclk_in);
		checked++;
		if (rsp_out !== '0 || busy_out !== 1'b0)
			bad("reset state wrong");
		rstn_in = 1;
		send(5'h00, 8'h01, 8'h01, 16'h0, {5'b00010, 6'h00, 1'b0, 8'h00, 16'h0, 8'h02}, {CTL_ALL, 1'b1, 8'h2F, 16'h0, 8'hFF});
		r.valid = 1'b0;
		repeat (4) @(negedge mclk_in);
		if (eq.size() != 0)
			bad("missing done");
		summarize();
	end
endmodule
